// File: logic/ista_pkg.sv
package ista_pkg;
  // ---------------------------------------------------------------
  // slave register map
  // ---------------------------------------------------------------
  localparam logic [7:0] S_CTRL_OFS = 8'h00;
  localparam logic [7:0] S_STAT_OFS = 8'h04;
  localparam logic [7:0] S_DATA_OFS = 8'h08;
  localparam logic [7:0] S_OWN_OFS  = 8'h0C;
  localparam int CTL_REL   = 0;
  localparam int CTL_SEN   = 1;
  localparam int CTL_A10   = 2;
  localparam int CTL_SIEN  = 3;
  localparam int CTL_SLAVE_COLLISION_DETECT_EN = 4;
  localparam int CTL_ADDRESS_HOLD_ENABLE  = 5;
  localparam int CTL_DATA_HOLD_ENABLE  = 6;
  localparam logic [6:0] CTL_RST = 7'h01;
  localparam logic [7:0] OWN_RST = 8'h00;
  localparam int ST_BF  = 0;
  localparam int ST_RD  = 1;
  localparam int ST_S   = 2;
  localparam int ST_P   = 3;
  localparam int ST_UA  = 4;
  localparam int ST_ACK = 5;
  localparam int ST_EVT = 6;
  localparam int ST_BCL = 7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] TX_LAST   = 4'h7;
  // ---------------------------------------------------------------
  // master register map
  // ---------------------------------------------------------------
  localparam logic [7:0] M_CMD_OFS  = 8'h00;
  localparam logic [7:0] M_DATA_OFS = 8'h04;
  localparam logic [7:0] M_STAT_OFS = 8'h08;
  localparam logic [1:0] CMD_START = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ  = 2'h2;
  localparam logic [1:0] CMD_STOP  = 2'h3;
  localparam int MC_ACK  = 2;
  localparam int MS_BUSY = 0;
  localparam int MS_NACK = 1;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_QTR_NS    = 2500;
  localparam logic [7:0] SCL_QTR_CYC =
    8'((SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage : ista_pkg

// File: logic/ista_link_if.sv
`timescale 1ns/10ps
interface ista_link_if;
  logic scl;
  logic sda;
  logic slv_scl_o;
  logic slv_scl_oe;
  logic slv_sda_o;
  logic slv_sda_oe;
  logic mst_scl_o;
  logic mst_scl_oe;
  logic mst_sda_o;
  logic mst_sda_oe;
  // ---------------------------------------------------------------
  // open-drain wired-and with pull-up
  // ---------------------------------------------------------------
  assign scl = ~((~slv_scl_oe & ~slv_scl_o) | (~mst_scl_oe & ~mst_scl_o));
  assign sda = ~((~slv_sda_oe & ~slv_sda_o) | (~mst_sda_oe & ~mst_sda_o));
  modport slv (input scl, sda,
               output slv_scl_o, slv_scl_oe, slv_sda_o, slv_sda_oe);
  modport mst (input scl, sda,
               output mst_scl_o, mst_scl_oe, mst_sda_o, mst_sda_oe);
endinterface : ista_link_if

// File: logic/ista_sync.sv
`timescale 1ns/10ps
module ista_sync #(
  parameter int             W       = 2,
  parameter logic [W-1:0]   RST_VAL = '1
) (
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_r <= RST_VAL;
      o_q    <= RST_VAL;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end
endmodule : ista_sync

// File: logic/ista_slave.sv
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/10ps
module ista_slave
  import ista_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  ista_link_if.slv         link
);
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ADDR_LO, S_RX, S_ACK, S_TX, S_TX_ACK
  } ista_slv_state_t;

  ista_slv_state_t st_r;
  ista_slv_state_t nxt_r;
  logic [1:0]  sync_q;
  logic        scl_s, sda_s, scl_d_r, sda_d_r;
  logic [3:0]  cnt_r;
  logic [7:0]  sh_r, buf_r, own_r;
  logic [6:0]  ctrl_r;
  logic        bf_r, rd_r, start_r, stop_r, ua_r, mack_r, evt_r, bcl_r;
  logic        a10_ok_r, stretch_r, scl_oe_r, sda_oe_r, zero_r;

  // ---------------------------------------------------------------
  // pin sampling and bus conditions
  // ---------------------------------------------------------------
  ista_sync #(.W(2), .RST_VAL(2'h3)) u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_d       ({link.scl, link.sda}),
    .o_q       (sync_q)
  );
  assign scl_s = sync_q[1];
  assign sda_s = sync_q[0];

  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire acc     = i_psel & i_penable & ~o_pready;
  wire wr      = acc & i_pwrite;
  wire rd      = acc & ~i_pwrite;
  wire hit_ctl = i_paddr == S_CTRL_OFS;
  wire hit_st  = i_paddr == S_STAT_OFS;
  wire hit_dat = i_paddr == S_DATA_OFS;
  wire hit_own = i_paddr == S_OWN_OFS;
  wire hit     = hit_ctl | hit_st | hit_dat | hit_own;
  wire ctl_wr  = wr & hit_ctl;
  wire st_wr   = wr & hit_st;
  wire dat_wr  = wr & hit_dat;
  wire dat_rd  = rd & hit_dat;
  wire own_wr  = wr & hit_own;

  // ---------------------------------------------------------------
  // byte decisions
  // ---------------------------------------------------------------
  wire a10     = ctrl_r[CTL_A10];
  wire rw      = sh_r[0];
  wire in_addr = st_r == S_ADDR;
  wire in_lo   = st_r == S_ADDR_LO;
  wire in_rx   = st_r == S_RX;
  wire in_ack  = st_r == S_ACK;
  wire in_tx   = st_r == S_TX;
  wire in_tack = st_r == S_TX_ACK;
  wire rx_done = scl_fall & (cnt_r == BYTE_BITS);
  wire hi_match = sh_r[7:1] == own_r[7:1];
  wire lo_match = sh_r == own_r;
  wire take_a  = in_addr & rx_done & hi_match & (~a10 | ~rw | a10_ok_r);
  wire take_l  = in_lo & rx_done & lo_match;
  wire take_r  = in_rx & rx_done;
  wire took    = take_a | take_l | take_r;
  wire lo_miss = in_lo & rx_done & ~lo_match;
  wire ack_end = in_ack & scl_fall;
  wire tack_end = in_tack & scl_fall;
  wire hold_rx = take_r ? ctrl_r[CTL_DATA_HOLD_ENABLE] : ctrl_r[CTL_ADDRESS_HOLD_ENABLE];
  wire hold_ack = (nxt_r == S_TX) | (nxt_r == S_ADDR_LO)
                | ((nxt_r == S_RX) & ctrl_r[CTL_SEN]);
  wire hold_req = (took & hold_rx)
                | (ack_end & hold_ack)
                | (tack_end & ~mack_r);
  wire bcl_set = in_tx & scl_rise & sda_oe_r & ~sda_s
               & ctrl_r[CTL_SLAVE_COLLISION_DETECT_EN];
  wire ev_set  = (start_c & ctrl_r[CTL_SIEN])
               | ack_end | tack_end | lo_miss;
  wire ua_set  = (take_a & a10 & ~rw) | (in_lo & rx_done);
  wire sda_drv = in_tx ? ~sh_r[7] : in_ack;

  ista_slv_state_t nxt_sel;
  assign nxt_sel = (take_a & a10 & ~rw) ? S_ADDR_LO
                 : (take_a & rw) ? S_TX : S_RX;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r     <= S_IDLE;
      nxt_r    <= S_IDLE;
      cnt_r    <= 4'h0;
      sh_r     <= 8'h00;
      rd_r     <= 1'b0;
      mack_r   <= 1'b0;
      a10_ok_r <= 1'b0;
    end else begin
      if (start_c) begin
        st_r  <= S_ADDR;
        cnt_r <= 4'h0;
      end else if (stop_c) begin
        st_r     <= S_IDLE;
        a10_ok_r <= 1'b0;
      end else begin
        unique case (st_r)
          S_IDLE: begin
          end
          S_ADDR, S_ADDR_LO, S_RX: begin
            if (scl_rise) begin
              sh_r  <= {sh_r[6:0], sda_s};
              cnt_r <= cnt_r + 4'h1;
            end else if (rx_done) begin
              st_r  <= took ? S_ACK : S_IDLE;
              nxt_r <= nxt_sel;
              if (take_a) rd_r <= rw;
              if (take_l) a10_ok_r <= 1'b1;
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              st_r  <= nxt_r;
              cnt_r <= 4'h0;
            end
          end
          S_TX: begin
            if (bcl_set) begin
              st_r <= S_IDLE;
            end else if (scl_fall) begin
              sh_r  <= {sh_r[6:0], 1'b0};
              cnt_r <= cnt_r + 4'h1;
              if (cnt_r == TX_LAST) st_r <= S_TX_ACK;
            end
          end
          S_TX_ACK: begin
            if (scl_rise) begin
              mack_r <= sda_s;
            end else if (scl_fall) begin
              st_r  <= mack_r ? S_IDLE : S_TX;
              cnt_r <= 4'h0;
            end
          end
        endcase
      end
      if (dat_wr) sh_r <= i_pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // buffer and address registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      buf_r <= 8'h00;
      own_r <= OWN_RST;
    end else begin
      if (took) buf_r <= sh_r;
      else if (dat_wr) buf_r <= i_pwdata[7:0];
      if (own_wr) own_r <= i_pwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // control and status flags, set wins over clear, except CTL_REL, where the hold_req clear wins over a write
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_r  <= CTL_RST;
      bf_r    <= 1'b0;
      ua_r    <= 1'b0;
      evt_r   <= 1'b0;
      bcl_r   <= 1'b0;
      start_r <= 1'b0;
      stop_r  <= 1'b0;
    end else begin
      if (ctl_wr) ctrl_r <= i_pwdata[6:0];
      if (own_wr) ctrl_r[CTL_REL] <= 1'b1;
      if (hold_req) ctrl_r[CTL_REL] <= 1'b0;
      bf_r  <= took | (bf_r & ~dat_rd);
      ua_r  <= ua_set | (ua_r & ~own_wr);
      evt_r <= ev_set | (evt_r & ~(st_wr & i_pwdata[ST_EVT]));
      bcl_r <= bcl_set | (bcl_r & ~(st_wr & i_pwdata[ST_BCL]));
      start_r <= start_c | (start_r & ~stop_c);
      stop_r  <= stop_c | (stop_r & ~start_c);
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      stretch_r <= 1'b0;
      scl_oe_r  <= 1'b1;
      sda_oe_r  <= 1'b1;
      zero_r    <= 1'b0;
      scl_d_r   <= 1'b1;
      sda_d_r   <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      if (start_c | stop_c) stretch_r <= 1'b0;
      else if (hold_req) stretch_r <= 1'b1;
      else if (ctrl_r[CTL_REL]) stretch_r <= 1'b0;
      scl_oe_r <= ~(stretch_r & ~ctrl_r[CTL_REL]);
      sda_oe_r <= ~sda_drv;
    end
  end

  assign link.slv_scl_o  = zero_r;
  assign link.slv_sda_o  = zero_r;
  assign link.slv_scl_oe = scl_oe_r;
  assign link.slv_sda_oe = sda_oe_r;

  // ---------------------------------------------------------------
  // apb answer
  // ---------------------------------------------------------------
  logic [7:0] stat_w;
  assign stat_w[ST_BF]  = bf_r;
  assign stat_w[ST_RD]  = rd_r;
  assign stat_w[ST_S]   = start_r;
  assign stat_w[ST_P]   = stop_r;
  assign stat_w[ST_UA]  = ua_r;
  assign stat_w[ST_ACK] = mack_r;
  assign stat_w[ST_EVT] = evt_r;
  assign stat_w[ST_BCL] = bcl_r;

  wire [7:0] rdata = hit_ctl ? {1'b0, ctrl_r}
                   : hit_st  ? stat_w
                   : hit_dat ? buf_r
                   : hit_own ? own_r : 8'h00;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= acc;
      o_pslverr <= acc & ~hit;
      o_prdata  <= rd ? {24'h00_0000, rdata} : 32'h0000_0000;
    end
  end
endmodule : ista_slave

// File: logic/ista_master.sv
`timescale 1ns/10ps
module ista_master
  import ista_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  ista_link_if.mst         link
);
  typedef enum logic [1:0] {M_IDLE, M_START, M_BYTE, M_STOP} ista_mst_state_t;

  ista_mst_state_t st_r;
  logic [1:0] sync_q;
  logic       scl_s, sda_s;
  logic [7:0] div_r, tx_r;
  logic [2:0] ph_r;
  logic [3:0] bit_r;
  logic [8:0] frame_r, rx_r;
  logic       scl_oe_r, sda_oe_r, zero_r;

  ista_sync #(.W(2), .RST_VAL(2'h3)) u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_d       ({link.scl, link.sda}),
    .o_q       (sync_q)
  );
  assign scl_s = sync_q[1];
  assign sda_s = sync_q[0];

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire acc     = i_psel & i_penable & ~o_pready;
  wire busy    = st_r != M_IDLE;
  wire hit_cmd = i_paddr == M_CMD_OFS;
  wire hit_dat = i_paddr == M_DATA_OFS;
  wire hit_st  = i_paddr == M_STAT_OFS;
  wire hit     = hit_cmd | hit_dat | hit_st;
  wire go      = acc & i_pwrite & hit_cmd & ~busy;
  wire refuse  = acc & ~hit | (acc & i_pwrite & hit_cmd & busy);
  wire [1:0] cmd = i_pwdata[1:0];

  // ---------------------------------------------------------------
  // quarter-bit divider, waits out clock stretching in phase 2
  // ---------------------------------------------------------------
  wire tick = div_r == SCL_QTR_CYC - 8'h01;
  wire adv  = tick & ((ph_r != 3'h2) | scl_s);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) div_r <= 8'h00;
    else div_r <= tick ? 8'h00 : div_r + 8'h01;
  end

  // ---------------------------------------------------------------
  // bus sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r     <= M_IDLE;
      ph_r     <= 3'h0;
      bit_r    <= 4'h0;
      frame_r  <= 9'h1FF;
      rx_r     <= 9'h000;
      scl_oe_r <= 1'b1;
      sda_oe_r <= 1'b1;
    end else if (go) begin
      ph_r    <= 3'h0;
      bit_r   <= 4'h0;
      frame_r <= (cmd == CMD_WRITE) ? {tx_r, 1'b1}
                                    : {8'hFF, i_pwdata[MC_ACK]};
      unique case (cmd)
        CMD_START: st_r <= M_START;
        CMD_STOP:  st_r <= M_STOP;
        default:   st_r <= M_BYTE;
      endcase
    end else if (adv & busy) begin
      ph_r <= ph_r + 3'h1;
      unique case (ph_r)
        3'h0: sda_oe_r <= (st_r == M_BYTE) ? frame_r[8] : (st_r != M_STOP);
        3'h1: scl_oe_r <= 1'b1;
        3'h2: rx_r <= {rx_r[7:0], sda_s};
        3'h3: begin
          if (st_r == M_BYTE) begin
            scl_oe_r <= 1'b0;
            frame_r  <= {frame_r[7:0], 1'b1};
            bit_r    <= bit_r + 4'h1;
            ph_r     <= 3'h0;
            if (bit_r == BYTE_BITS) st_r <= M_IDLE;
          end else begin
            sda_oe_r <= st_r == M_STOP;
            if (st_r == M_STOP) st_r <= M_IDLE;
          end
        end
        3'h4: begin
          scl_oe_r <= 1'b0;
          st_r     <= M_IDLE;
        end
        default: st_r <= M_IDLE;
      endcase
    end
  end

  assign link.mst_scl_o  = zero_r;
  assign link.mst_sda_o  = zero_r;
  assign link.mst_scl_oe = scl_oe_r;
  assign link.mst_sda_oe = sda_oe_r;

  // ---------------------------------------------------------------
  // registers and apb answer
  // ---------------------------------------------------------------
  wire [31:0] stat_w = {16'h0000, rx_r[8:1], 6'h00, rx_r[0], busy};
  wire [31:0] rdata  = hit_dat ? {24'h00_0000, tx_r}
                     : hit_st  ? stat_w : 32'h0000_0000;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_r      <= 8'h00;
      zero_r    <= 1'b0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      if (acc & i_pwrite & hit_dat) tx_r <= i_pwdata[7:0];
      o_pready  <= acc;
      o_pslverr <= refuse;
      o_prdata  <= (acc & ~i_pwrite) ? rdata : 32'h0000_0000;
    end
  end
endmodule : ista_master

// File: verification/ista_link_props.sv
`timescale 1ns/10ps
module ista_link_props (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic slv_scl_o,
  input wire logic slv_scl_oe,
  input wire logic slv_sda_o,
  input wire logic slv_sda_oe
);
  // ---------------------------------------------------------------
  // slave side of the wire
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  a_slv_open_drain: assert property (!slv_scl_o && !slv_sda_o)
    else $error("slave output level not low");
  a_sda_scl_low: assert property ($changed(slv_sda_oe) |-> !scl)
    else $error("slave data changed while clock high");
  a_sda_after_fall: assert property (
    $changed(slv_sda_oe) |-> !$past(scl, 3))
    else $error("slave data changed too soon after clock fall");
  a_stretch_low: assert property ($fell(slv_scl_oe) |-> !scl)
    else $error("slave pulled clock while it was high");
  a_stretch_late: assert property (
    $fell(slv_scl_oe) |-> !$past(scl, 3))
    else $error("slave stretch began too soon after clock fall");
  a_stretch_hold: assert property (
    $fell(slv_scl_oe) |=> !slv_scl_oe [*4])
    else $error("slave stretch released without software");
  a_idle_stop: assert property (
    (scl && $rose(sda)) |=> (slv_scl_oe && slv_sda_oe) [*8])
    else $error("slave drives the bus after stop");
  a_quiet_start: assert property (
    (scl && $fell(sda)) |=> slv_sda_oe [*8])
    else $error("slave drives data right after start");
endmodule : ista_link_props

// File: verification/i2c_slave_transmit_addr10_test.sv
`timescale 1ns/10ps
module i2c_slave_transmit_addr10_test;
  import ista_pkg::*;
  localparam int S = 0;
  localparam int M = 1;
  logic        i_clk;
  logic        i_sys_rst;
  logic [1:0]  psel;
  logic [1:0]  penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata [2];
  logic [1:0]  pready;
  logic [1:0]  pslverr;
  logic [31:0] rdata;
  logic        serr;
  logic [7:0]  txb [2];
  int          errors;
  int          checks_done;

  ista_link_if ista_link_if_i ();
  ista_slave ista_slave_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_psel(psel[0]), .i_penable(penable[0]), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata[0]),
    .o_pready(pready[0]), .o_pslverr(pslverr[0]), .link(ista_link_if_i));
  ista_master ista_master_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_psel(psel[1]), .i_penable(penable[1]), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata[1]),
    .o_pready(pready[1]), .o_pslverr(pslverr[1]), .link(ista_link_if_i));
  ista_link_props ista_link_props_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .scl(ista_link_if_i.scl), .sda(ista_link_if_i.sda),
    .slv_scl_o(ista_link_if_i.slv_scl_o),
    .slv_scl_oe(ista_link_if_i.slv_scl_oe),
    .slv_sda_o(ista_link_if_i.slv_sda_o),
    .slv_sda_oe(ista_link_if_i.slv_sda_oe));

  always #5 i_clk = ~i_clk;

  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic apb(input int m, input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel[m] <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_clk);
    penable[m] <= 1'b1;
    n = 0;
    // look at pready mid-cycle, then release on the edge that samples it
    do begin
      @(negedge i_clk);
      n++;
    end while (pready[m] !== 1'b1 && n < 50);
    if (pready[m] !== 1'b1) errors++;
    rdata = prdata[m];
    serr  = pslverr[m];
    @(posedge i_clk);
    psel[m]    <= 1'b0;
    penable[m] <= 1'b0;
    @(posedge i_clk);
  endtask : apb

  task automatic wr(input int m, input logic [7:0] a, input logic [31:0] d);
    apb(m, 1'b1, a, d);
  endtask : wr

  task automatic chk(input int m, input logic [7:0] a,
                     input logic [31:0] mask, exp, input string nm);
    apb(m, 1'b0, a, 32'h0000_0000);
    check(nm, rdata & mask, exp);
  endtask : chk

  // master command, then poll busy
  task automatic mcmd(input logic [31:0] c);
    int n;
    wr(M, M_CMD_OFS, c);
    n = 0;
    do begin
      apb(M, 1'b0, M_STAT_OFS, 32'h0000_0000);
      n++;
    end while (rdata[MS_BUSY] !== 1'b0 && n < 4000);
    if (rdata[MS_BUSY] !== 1'b0) errors++;
  endtask : mcmd

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  initial begin
    #900_000;
    errors++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    i_sys_rst = 1'b1;
    psel = 2'b00;
    penable = 2'b00;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    errors = 0;
    checks_done = 0;
    txb[0] = 8'h3C;
    txb[1] = 8'hC3;
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    chk(S, S_CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0001, "ctrl reset");
    chk(S, S_STAT_OFS, 32'hFFFF_FFFF, 32'h0000_0000, "stat reset");
    apb(S, 1'b0, 8'h10, 32'h0000_0000);
    check("unmapped", {31'h0, serr}, 32'h0000_0001);
    wr(S, S_OWN_OFS, 32'h0000_00A4);
    wr(S, S_CTRL_OFS, 32'h0000_0009);
    mcmd(32'(CMD_START));
    chk(S, S_STAT_OFS, 32'h44, 32'h44, "start seen");
    wr(S, S_STAT_OFS, 32'h0000_0040);
    wr(M, M_DATA_OFS, 32'h0000_00A5);
    mcmd(32'(CMD_WRITE));
    chk(M, M_STAT_OFS, 32'h02, 32'h00, "addr ack");
    chk(S, S_STAT_OFS, 32'hFF, 32'h47, "read addr");
    chk(S, S_CTRL_OFS, 32'h01, 32'h00, "addr stretch");
    check("scl held", {31'h0, ista_link_if_i.scl}, 32'h0);
    chk(S, S_DATA_OFS, 32'hFFFF_FFFF, 32'h0000_00A5, "addr buf");
    chk(S, S_STAT_OFS, 32'h01, 32'h00, "bf clear");
    for (int i = 0; i < 2; i++) begin
      wr(S, S_STAT_OFS, 32'h0000_0040);
      wr(S, S_DATA_OFS, {24'h0, txb[i]});
      wr(S, S_CTRL_OFS, 32'h0000_0009);
      mcmd(32'(CMD_READ) | (32'(i) << MC_ACK));
      chk(M, M_STAT_OFS, 32'hFF00, {16'h0, txb[i], 8'h0}, "rx");
      chk(S, S_STAT_OFS, 32'h60, 32'h40 | (32'(i) << 5), "ack");
      chk(S, S_CTRL_OFS, 32'h01, 32'(i), "ack stretch");
    end
    mcmd(32'(CMD_READ) | (32'h1 << MC_ACK));
    chk(M, M_STAT_OFS, 32'hFF00, 32'hFF00, "idle after nack");
    mcmd(32'(CMD_STOP));
    chk(S, S_STAT_OFS, 32'h0C, 32'h08, "stop seen");
    check("sda idle", {31'h0, ista_link_if_i.sda}, 32'h1);
    apb(S, 1'b0, S_DATA_OFS, 32'h0000_0000);
    wr(S, S_CTRL_OFS, 32'h0000_0005);
    wr(S, S_OWN_OFS, 32'h0000_00F2);
    wr(S, S_STAT_OFS, 32'h0000_0040);
    mcmd(32'(CMD_START));
    wr(M, M_DATA_OFS, 32'h0000_00F2);
    mcmd(32'(CMD_WRITE));
    chk(M, M_STAT_OFS, 32'h02, 32'h00, "high ack");
    chk(S, S_STAT_OFS, 32'h51, 32'h51, "high stat");
    chk(S, S_CTRL_OFS, 32'h01, 32'h00, "high stretch");
    apb(S, 1'b0, S_DATA_OFS, 32'h0000_0000);
    wr(S, S_STAT_OFS, 32'h0000_0040);
    wr(S, S_OWN_OFS, 32'h0000_0033);
    chk(S, S_CTRL_OFS, 32'h01, 32'h01, "own release");
    chk(S, S_STAT_OFS, 32'h10, 32'h00, "ua clear");
    wr(M, M_DATA_OFS, 32'h0000_0034);
    mcmd(32'(CMD_WRITE));
    chk(M, M_STAT_OFS, 32'h02, 32'h02, "low nack");
    chk(S, S_STAT_OFS, 32'h51, 32'h50, "low stat");
    chk(S, S_CTRL_OFS, 32'h01, 32'h01, "low release");
    mcmd(32'(CMD_STOP));
    finish_test();
  end
endmodule : i2c_slave_transmit_addr10_test
